// ### rtl/vbrt_top.sv
`timescale 1ns/1ns
module vbrt_top #(
    parameter int STEP_CYCLES = vbrt_pkg::STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmdValid,
    input wire vbrt_pkg::vbrt_cmd_type cmdCode,
    input wire logic [7:0] cmdArg,
    input wire logic autoFormat,
    input wire logic txInValid,
    input wire logic [7:0] txInData,
    input wire logic txInLast,
    input wire logic replyCountValid,
    input wire logic [3:0] replyCount,
    output logic txInTaken,
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxEnd,
    output logic rxReady,
    input wire logic hostReady,
    output logic hostValid,
    output logic [7:0] hostMid,
    output logic [7:0] hostData,
    output logic hostLast,
    input wire logic hostChar,
    output logic busy,
    output logic done,
    output logic noData,
    output logic [7:0] txIdentifier,
    output logic [7:0] replyTimeout
);
    import vbrt_pkg::*;

    vbrt_state_type stQ, stD;
    logic [7:0] idQ, toQ, sumQ, paramQ, monParamQ, midQ, hostMidQ, hostDataQ;
    logic [7:0] txDataQ, chkQ;
    logic [4:0] dataCntQ;
    logic [3:0] countQ, repliesQ;
    logic [1:0] byteIdxQ;
    logic idPendQ, sumPendQ, fmtQ, anyQ, fwdQ, abortQ, takenQ, firstOutQ;
    logic txValidQ, txLastQ, hostValidQ, hostLastQ, busyQ, doneQ, noDataQ;
    logic fifoValid;
    logic [RX_WORD_W-1:0] fifoData;

    vbrt_timer_if tmrIf ();

    vbrt_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .tmr(tmrIf.timer)
    );

    // Bus bytes queue here so a slow host stalls the receiver, not the logic
    vbrt_fifo #(.WIDTH(RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rstn(rstn),
        .inValid(rxValid),
        .inData({rxEnd, rxData}),
        .inReady(rxReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(hostReady)
    );

    wire logic stIdle = stQ == ST_IDLE;
    wire logic stSend = stQ == ST_SEND;
    wire logic stWait = stQ == ST_WAIT;
    wire logic stMon = stQ == ST_MON;

    // Transmit side
    wire logic startReq = stIdle && txInValid && !takenQ;
    wire logic slotFree = !txValidQ || txReady;
    wire logic emitId = stSend && idPendQ && slotFree;
    wire logic takeByte = stSend && !idPendQ && !sumPendQ && txInValid && !takenQ && slotFree;
    wire logic capHit = fmtQ && dataCntQ == MAX_TX_DATA;
    wire logic emitByte = takeByte && !capHit;
    wire logic emitSum = stSend && sumPendQ && slotFree;
    wire logic [7:0] sumNeg = 8'(8'h00 - sumQ);
    wire logic enterWait = emitSum || (takeByte && txInLast && !fmtQ);

    // Command side; commands wait while an operation runs
    wire logic cmdTake = cmdValid && stIdle && !startReq;
    wire logic restoreCmd = cmdTake && (cmdCode == CMD_RESTORE_DEFAULTS
        || cmdCode == CMD_WARM_RESTART || cmdCode == CMD_FULL_RESTART);
    wire logic singleCmd = cmdTake && cmdCode == CMD_GET_SINGLE_MESSAGE;
    wire logic monCmd = cmdTake && cmdCode == CMD_MONITOR_PARAMETER;

    // Receive side: index 0 is the sender identifier, 1 the first data byte
    wire logic pop = fifoValid && hostReady;
    wire logic [7:0] rxByte = fifoData[7:0];
    wire logic rxLastByte = fifoData[8];
    wire logic firstData = pop && byteIdxQ == 2'd1;
    wire logic isReply = stWait && (anyQ || rxByte == paramQ || rxByte == MULTI_SECTION_PID);
    wire logic isMon = stMon && rxByte == monParamQ;
    wire logic matchNow = firstData && (isReply || isMon);
    wire logic fwdNow = matchNow || (pop && byteIdxQ == 2'd2 && fwdQ);
    wire logic replyEnd = fwdNow && rxLastByte && stWait;
    wire logic countHit = replyEnd && countQ != 4'h0 && repliesQ + 4'h1 == countQ;
    wire logic timedOut = stWait && tmrIf.expired && !replyEnd;
    wire logic abortNow = (stWait || stMon) && abortQ && !fwdQ && !fwdNow;
    wire logic finish = countHit || timedOut || abortNow;

    assign tmrIf.load = enterWait || singleCmd || (replyEnd && !countHit);
    assign tmrIf.stop = finish;
    assign tmrIf.steps = toQ;

    always_comb begin
        stD = stQ;
        unique case (stQ)
            ST_IDLE: begin
                if (startReq) begin
                    stD = ST_SEND;
                end else if (singleCmd) begin
                    stD = ST_WAIT;
                end else if (monCmd) begin
                    stD = ST_MON;
                end
            end
            ST_SEND: begin
                if (enterWait) begin
                    stD = ST_WAIT;
                end
            end
            ST_WAIT, ST_MON: begin
                if (finish) begin
                    stD = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stQ <= ST_IDLE;
            busyQ <= 1'b0;
            doneQ <= 1'b0;
            noDataQ <= 1'b0;
        end else begin
            stQ <= stD;
            busyQ <= stD != ST_IDLE;
            doneQ <= finish;
            noDataQ <= timedOut && repliesQ == 4'h0;
        end
    end

    // Settings live only in flops, so any restart brings back the defaults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idQ <= DEFAULT_ID;
            toQ <= DEFAULT_TIMEOUT;
        end else if (restoreCmd) begin
            idQ <= DEFAULT_ID;
            toQ <= DEFAULT_TIMEOUT;
        end else if (cmdTake && cmdCode == CMD_SET_TX_IDENTIFIER) begin
            idQ <= cmdArg;
        end else if (cmdTake && cmdCode == CMD_SET_REPLY_TIMEOUT && cmdArg != 8'h00) begin
            toQ <= cmdArg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fmtQ <= 1'b0;
            idPendQ <= 1'b0;
            sumPendQ <= 1'b0;
            sumQ <= 8'h00;
            dataCntQ <= 5'h00;
            paramQ <= 8'h00;
            takenQ <= 1'b0;
        end else begin
            takenQ <= takeByte;
            if (startReq) begin
                fmtQ <= autoFormat;
                idPendQ <= autoFormat;
                sumPendQ <= 1'b0;
                sumQ <= idQ;
                dataCntQ <= 5'h00;
            end else begin
                idPendQ <= idPendQ && !emitId;
                sumPendQ <= (sumPendQ && !emitSum) || (takeByte && txInLast && fmtQ);
                if (emitByte) begin
                    sumQ <= 8'(sumQ + txInData);
                    dataCntQ <= dataCntQ + 5'h01;
                end
            end
            // A leading parameter-request byte means the next byte names it
            if (emitByte && (dataCntQ == 5'h00
                || (dataCntQ == 5'h01 && paramQ == PARAM_REQUEST_PID))) begin
                paramQ <= txInData;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txValidQ <= 1'b0;
            txDataQ <= 8'h00;
            txLastQ <= 1'b0;
        end else if (emitId || emitByte || emitSum) begin
            txValidQ <= 1'b1;
            txDataQ <= emitId ? idQ : (emitSum ? sumNeg : txInData);
            txLastQ <= emitSum || (emitByte && txInLast && !fmtQ);
        end else if (txReady) begin
            txValidQ <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            countQ <= 4'h0;
            repliesQ <= 4'h0;
            anyQ <= 1'b0;
            monParamQ <= 8'h00;
            abortQ <= 1'b0;
        end else begin
            abortQ <= (!stIdle && hostChar) || (abortQ && !stIdle && !finish);
            if (startReq) begin
                countQ <= replyCountValid ? replyCount : 4'h0;
                repliesQ <= 4'h0;
                anyQ <= 1'b0;
            end else if (singleCmd) begin
                countQ <= SINGLE_REPLY;
                repliesQ <= 4'h0;
                anyQ <= 1'b1;
            end else if (replyEnd && repliesQ != 4'hF) begin
                repliesQ <= repliesQ + 4'h1;
            end
            if (monCmd) begin
                monParamQ <= cmdArg;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byteIdxQ <= 2'd0;
            fwdQ <= 1'b0;
            midQ <= 8'h00;
            hostValidQ <= 1'b0;
            hostMidQ <= 8'h00;
            hostDataQ <= 8'h00;
            hostLastQ <= 1'b0;
        end else begin
            hostValidQ <= fwdNow;
            if (pop) begin
                byteIdxQ <= rxLastByte ? 2'd0 : (byteIdxQ == 2'd2 ? 2'd2 : byteIdxQ + 2'd1);
                fwdQ <= rxLastByte ? 1'b0 : (firstData ? matchNow : fwdQ);
                midQ <= byteIdxQ == 2'd0 ? rxByte : midQ;
            end
            if (fwdNow) begin
                hostMidQ <= midQ;
                hostDataQ <= rxByte;
                hostLastQ <= rxLastByte;
            end
        end
    end

    assign txInTaken = takenQ;
    assign txValid = txValidQ;
    assign txData = txDataQ;
    assign txLast = txLastQ;
    assign hostValid = hostValidQ;
    assign hostMid = hostMidQ;
    assign hostData = hostDataQ;
    assign hostLast = hostLastQ;
    assign busy = busyQ;
    assign done = doneQ;
    assign noData = noDataQ;
    assign txIdentifier = idQ;
    assign replyTimeout = toQ;

    // Helper state for the checks: running sum, first-byte marker and count of sent bytes
    // Counted on the transmitter side, so the cap is judged by what left, not by dataCntQ
    wire logic txFire = txValidQ && txReady;
    logic [4:0] sentCntQ;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chkQ <= 8'h00;
            firstOutQ <= 1'b1;
            sentCntQ <= 5'h00;
        end else if (txFire) begin
            chkQ <= txLastQ ? 8'h00 : 8'(chkQ + txDataQ);
            firstOutQ <= txLastQ;
            sentCntQ <= txLastQ ? 5'h00 : 5'(sentCntQ + 5'h01);
        end
    end

    a_restore_id: assert property (@(posedge clk) disable iff (!rstn)
        restoreCmd |=> idQ == DEFAULT_ID && toQ == DEFAULT_TIMEOUT)
        else $error("restore did not bring back default identifier");
    a_set_id: assert property (@(posedge clk) disable iff (!rstn)
        cmdTake && cmdCode == CMD_SET_TX_IDENTIFIER |=> idQ == $past(cmdArg))
        else $error("identifier not taken from command");
    a_id_stable: assert property (@(posedge clk) disable iff (!rstn)
        $changed(idQ) |-> $past(cmdTake))
        else $error("identifier changed without a command");
    a_first_id: assert property (@(posedge clk) disable iff (!rstn)
        txFire && firstOutQ && fmtQ |-> txDataQ == idQ)
        else $error("formatted frame does not open with identifier");
    a_sum_zero: assert property (@(posedge clk) disable iff (!rstn)
        txFire && txLastQ && fmtQ |-> 8'(chkQ + txDataQ) == 8'h00)
        else $error("formatted frame does not sum to zero");
    a_tx_cap: assert property (@(posedge clk) disable iff (!rstn)
        txFire && txLastQ && fmtQ |-> sentCntQ <= 5'(MAX_TX_DATA + 5'h01))
        else $error("more than the allowed data bytes sent");
    a_reply_fwd: assert property (@(posedge clk) disable iff (!rstn)
        firstData && stWait && rxByte == MULTI_SECTION_PID
        |=> hostValidQ && hostDataQ == MULTI_SECTION_PID)
        else $error("multisection reply not forwarded");
    a_mon_match: assert property (@(posedge clk) disable iff (!rstn)
        firstData && stMon |=> hostValidQ == ($past(rxByte) == monParamQ))
        else $error("monitor match on first data byte wrong");
    a_no_data: assert property (@(posedge clk) disable iff (!rstn)
        timedOut && repliesQ == 4'h0 |=> noDataQ && doneQ && stIdle)
        else $error("timeout without replies did not report no data");
    a_reply_rearm: assert property (@(posedge clk) disable iff (!rstn)
        replyEnd && !countHit && !abortQ |=> stWait ##1 !tmrIf.expired)
        else $error("reply did not keep the wait running");
    a_count_stop: assert property (@(posedge clk) disable iff (!rstn)
        countHit |=> doneQ && !noDataQ && stIdle)
        else $error("reply count reached but wait continued");
    a_single: assert property (@(posedge clk) disable iff (!rstn)
        singleCmd |=> stWait && countQ == SINGLE_REPLY)
        else $error("single-message command did not arm one reply");
    a_abort: assert property (@(posedge clk) disable iff (!rstn)
        abortNow |=> stIdle ##0 doneQ)
        else $error("abort did not end the operation");
endmodule : vbrt_top

// ### rtl/vbrt_pkg.sv
// How it works
// - After defaults are restored the transmit identifier is hex AC (decimal 172).
// - The set-identifier command's byte is used in every later auto-formatted frame.
// - Identifier holds until defaults, warm restart, full restart or power cycle.
// - A reply whose first data byte equals the requested parameter is a single answer.
// - Replies whose data begins with C0 are multisection answers and are accepted too.
// - Every section is forwarded to the host unassembled; responders may interleave.
// - Wait for replies up to the timeout (default 1.5 s), else report no data.
// - Each reply restarts the timeout; the exchange ends after one quiet timeout.
// - Timeout is set in 100 ms steps from 0.1 s to 25.5 s.
// - Optional reply count 1 to F after data bytes returns after that many replies; a count of 0 sets no limit.
// - The get-single-message command behaves as a reply count of one.
// - Receive length is unlimited; auto-formatted transmit takes at most 21 data bytes.
// - The monitor-parameter command matches its argument against each first data byte.
// - Auto formatting prefixes the identifier and appends the checksum; else bytes go raw.
// - A host character aborts the operation after the current forwarded frame ends.
package vbrt_pkg;
    localparam logic [7:0] DEFAULT_ID = 8'hAC;
    localparam logic [7:0] DEFAULT_TIMEOUT = 8'h0F;
    localparam int STEP_MS = 100;
    localparam int CLK_HZ = 20_000_000;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    localparam logic [7:0] MULTI_SECTION_PID = 8'hC0;
    localparam logic [7:0] PARAM_REQUEST_PID = 8'h00;
    localparam logic [4:0] MAX_TX_DATA = 5'h15;
    localparam logic [3:0] SINGLE_REPLY = 4'h1;
    localparam int FIFO_DEPTH = 4;
    localparam int RX_WORD_W = 9;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_SET_TX_IDENTIFIER = 4'h1,
        CMD_SET_REPLY_TIMEOUT = 4'h2,
        CMD_GET_SINGLE_MESSAGE = 4'h3,
        CMD_RESTORE_DEFAULTS = 4'h4,
        CMD_WARM_RESTART = 4'h5,
        CMD_FULL_RESTART = 4'h6,
        CMD_MONITOR_PARAMETER = 4'h7
    } vbrt_cmd_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEND = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_MON = 4'b1000
    } vbrt_state_type;
endpackage : vbrt_pkg

// ### rtl/vbrt_timer_if.sv
`timescale 1ns/1ns
interface vbrt_timer_if;
    logic load;
    logic stop;
    logic [7:0] steps;
    logic expired;
    modport ctrl (output load, output stop, output steps, input expired);
    modport timer (input load, input stop, input steps, output expired);
endinterface : vbrt_timer_if

// ### rtl/vbrt_timer.sv
`timescale 1ns/1ns
module vbrt_timer #(
    parameter int STEP_CYCLES = vbrt_pkg::STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    vbrt_timer_if.timer tmr
);
    import vbrt_pkg::*;
    logic [31:0] preQ;
    logic [7:0] leftQ;
    logic runQ;
    logic expQ;
    wire logic stepDone = preQ == 32'(STEP_CYCLES - 1);
    wire logic lastStep = runQ && stepDone && leftQ == 8'h01;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preQ <= 32'h0;
            leftQ <= 8'h00;
            runQ <= 1'b0;
            expQ <= 1'b0;
        end else begin
            expQ <= lastStep && !tmr.load && !tmr.stop;
            if (tmr.load) begin
                preQ <= 32'h0;
                leftQ <= tmr.steps;
                runQ <= 1'b1;
            end else if (tmr.stop || lastStep) begin
                runQ <= 1'b0;
            end else if (runQ) begin
                preQ <= stepDone ? 32'h0 : preQ + 32'h1;
                leftQ <= stepDone ? leftQ - 8'h01 : leftQ;
            end
        end
    end
    assign tmr.expired = expQ;

    a_load_restarts: assert property (@(posedge clk) disable iff (!rstn)
        tmr.load |=> !tmr.expired ##0 leftQ == $past(tmr.steps))
        else $error("timer load did not restart the count");
endmodule : vbrt_timer

// ### rtl/vbrt_fifo.sv
`timescale 1ns/1ns
module vbrt_fifo #(
    parameter int WIDTH = vbrt_pkg::RX_WORD_W,
    parameter int DEPTH = vbrt_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] memQ [DEPTH];
    logic [AW-1:0] wrQ;
    logic [AW-1:0] rdQ;
    logic [CW-1:0] cntQ;
    logic [CW-1:0] cntD;
    logic notFullQ;
    wire logic push = inValid && notFullQ;
    wire logic pop = outReady && cntQ != '0;

    assign cntD = push && !pop ? cntQ + CW'(1) : (pop && !push ? cntQ - CW'(1) : cntQ);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrQ <= '0;
            rdQ <= '0;
            cntQ <= '0;
            notFullQ <= 1'b1;
        end else begin
            wrQ <= push ? AW'(wrQ + AW'(1)) : wrQ;
            rdQ <= pop ? AW'(rdQ + AW'(1)) : rdQ;
            cntQ <= cntD;
            notFullQ <= cntD != CW'(DEPTH);
        end
    end

    // Storage carries no reset; only the pointers define contents
    always_ff @(posedge clk) begin
        if (push) begin
            memQ[wrQ] <= inData;
        end
    end

    assign inReady = notFullQ;
    assign outValid = cntQ != '0;
    assign outData = memQ[rdQ];

    a_fifo_full: assert property (@(posedge clk) disable iff (!rstn)
        notFullQ == (cntQ != CW'(DEPTH)))
        else $error("fifo full flag disagrees with count");
endmodule : vbrt_fifo

// ### verif/vbrt_partner.sv
`timescale 1ns/1ns
module vbrt_partner (
    input wire logic clk,
    input wire logic rxReady,
    output logic txReady,
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxEnd
);
    initial begin
        txReady = 1'b1;
        rxValid = 1'b0;
        rxData = 8'hA5;
        rxEnd = 1'b0;
    end

    // Random stalls keep the held transmit byte under test
    always @(negedge clk) begin
        txReady <= ($urandom % 4) != 0;
    end

    // Whole frames only, in order; each byte held until the fifo has room
    task automatic sendFrame(input logic [7:0] f[$], input int gap);
        repeat (gap) @(negedge clk);
        foreach (f[i]) begin
            rxValid = 1'b1;
            rxData = f[i];
            rxEnd = (i == f.size() - 1);
            do @(posedge clk); while (rxReady !== 1'b1);
            @(negedge clk);
        end
        rxValid = 1'b0;
        rxEnd = 1'b0;
        // Released line shows the inverse, not a stale copy
        rxData = ~rxData;
    endtask : sendFrame
endmodule : vbrt_partner

// ### verif/vehicle_bus_request_timing_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end

module vehicle_bus_request_timing_test;
    import vbrt_pkg::*;
    logic clk = 0, rstn = 0, cmdValid = 0, autoFormat = 1, txInValid = 0, txInLast = 0;
    logic replyCountValid = 0, hostReady = 1, hostChar = 0;
    vbrt_cmd_type cmdCode = CMD_NONE;
    logic [7:0] cmdArg = 8'h00, txInData = 8'h00, curId = 8'hAC;
    logic [3:0] replyCount = 4'h0;
    logic txInTaken, txValid, txLast, txReady, rxValid, rxEnd, rxReady;
    logic hostValid, hostLast, busy, done, noData;
    logic [7:0] txData, rxData, hostMid, hostData, txIdentifier, replyTimeout;
    int failures = 0, check_count = 0;
    logic [8:0] expTx[$];
    logic [16:0] expHost[$];
    vbrt_cmd_type rc[3] = '{CMD_RESTORE_DEFAULTS, CMD_WARM_RESTART, CMD_FULL_RESTART};

    always #25 clk = ~clk;

    vbrt_top #(.STEP_CYCLES(10)) DUT (.clk, .rstn, .cmdValid, .cmdCode, .cmdArg, .autoFormat,
        .txInValid, .txInData, .txInLast, .replyCountValid, .replyCount, .txInTaken, .txValid,
        .txData, .txLast, .txReady, .rxValid, .rxData, .rxEnd, .rxReady, .hostReady,
        .hostValid, .hostMid, .hostData, .hostLast, .hostChar, .busy, .done, .noData,
        .txIdentifier, .replyTimeout);

    vbrt_partner partner (.clk, .rxReady, .txReady, .rxValid, .rxData, .rxEnd);

    // Pop once before comparing; the macro reads its second value twice
    always @(posedge clk) begin : txMon
        logic [8:0] e;
        if (rstn && txValid && txReady) begin
            e = expTx.size() ? expTx.pop_front() : 9'h1FF;
            `CHK({txLast, txData}, e)
        end
    end

    always @(negedge clk) begin : hostMon
        logic [16:0] e;
        hostReady <= ($urandom % 4) != 0;
        if (hostValid === 1'b1) begin
            e = expHost.size() ? expHost.pop_front() : 17'h1FFFF;
            `CHK({hostMid, hostData, hostLast}, e)
        end
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic cmd(input vbrt_cmd_type c, input logic [7:0] a);
        cmdCode = c;
        cmdArg = a;
        cmdValid = 1'b1;
        if (c == CMD_SET_TX_IDENTIFIER) curId = a;
        if (c inside {CMD_RESTORE_DEFAULTS, CMD_WARM_RESTART, CMD_FULL_RESTART}) curId = 8'hAC;
        @(negedge clk) cmdValid = 1'b0;
        @(negedge clk);
    endtask : cmd

    task automatic request(input logic [7:0] d[$], input logic af, input logic [3:0] cnt,
                           input logic cv);
        logic [7:0] sum;
        sum = curId;
        autoFormat = af;
        replyCount = cnt;
        replyCountValid = cv;
        if (af) expTx.push_back({1'b0, curId});
        foreach (d[i]) begin
            // Formatted frames drop data bytes past the cap, checksum included
            if (af && i >= int'(MAX_TX_DATA)) continue;
            sum += d[i];
            expTx.push_back({!af && i == d.size() - 1, d[i]});
        end
        if (af) expTx.push_back({1'b1, 8'(-sum)});
        foreach (d[i]) begin
            txInValid = 1'b1;
            txInData = d[i];
            txInLast = (i == d.size() - 1);
            do @(negedge clk); while (txInTaken !== 1'b1);
        end
        txInValid = 1'b0;
        txInLast = 1'b0;
    endtask : request

    task automatic frame(input logic [7:0] f[$], input int gap, input logic fwd);
        for (int i = 1; fwd && i < f.size(); i++)
            expHost.push_back({f[0], f[i], i == f.size() - 1});
        partner.sendFrame(f, gap);
    endtask : frame

    task automatic waitDone(input logic nd, input int lim, input logic chk);
        for (int k = 0; k < lim && done !== 1'b1; k++) @(negedge clk);
        `CHK(done, 1'b1)
        if (chk) `CHK(noData, nd)
        `CHK(busy, 1'b0)
        @(negedge clk);
    endtask : waitDone

    task automatic endTest(input string name);
        `CHK(expHost.size(), 0)
        `CHK(expTx.size(), 0)
        $display("test %s finished", name);
    endtask : endTest

    initial begin
        #(50 * 20000);
        failures++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h49ECB0D7));
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        `CHK(txIdentifier, 8'hAC)
        `CHK(replyTimeout, 8'h0F)
        `CHK(rxReady, 1'b1)
        cmd(CMD_SET_REPLY_TIMEOUT, 8'h03);
        cmd(CMD_SET_REPLY_TIMEOUT, 8'h00);
        `CHK(replyTimeout, 8'h03)
        cmd(CMD_SET_TX_IDENTIFIER, 8'hB4);
        `CHK(txIdentifier, 8'hB4)
        endTest("settings");
        // Second reply lands after the first timeout would have ended the wait
        fork
            request('{8'h00, 8'hBE}, 1'b1, 4'h0, 1'b0);
            begin
                frame('{8'h80, 8'hBE, 8'h12}, 15, 1'b1);
                frame('{8'h81, 8'hC0, 8'h20, 8'h01, 8'hAA}, 20, 1'b1);
            end
            waitDone(1'b0, 300, 1'b1);
        join
        endTest("single and multisection");
        request('{8'h11, 8'h22, 8'h33}, 1'b0, 4'h0, 1'b0);
        waitDone(1'b1, 300, 1'b1);
        endTest("raw no data");
        fork
            request('{8'h00, 8'h5C}, 1'b1, 4'h2, 1'b1);
            begin
                frame('{8'h82, 8'h5C, 8'h01}, 15, 1'b1);
                frame('{8'h83, 8'h5C, 8'h02}, 3, 1'b1);
                frame('{8'h84, 8'h5C, 8'h03}, 12, 1'b0);
            end
            waitDone(1'b0, 300, 1'b1);
        join
        endTest("reply count");
        cmd(CMD_GET_SINGLE_MESSAGE, 8'h00);
        fork
            begin
                frame('{8'h90, 8'h33, 8'h44}, 2, 1'b1);
                frame('{8'h91, 8'h55}, 12, 1'b0);
            end
            waitDone(1'b0, 300, 1'b1);
        join
        endTest("get single");
        cmd(CMD_MONITOR_PARAMETER, 8'h5C);
        `CHK(busy, 1'b1)
        frame('{8'h92, 8'h5C, 8'h01}, 2, 1'b1);
        frame('{8'h93, 8'h77, 8'h02}, 2, 1'b0);
        repeat (6) @(negedge clk);
        hostChar = 1'b1;
        @(negedge clk) hostChar = 1'b0;
        waitDone(1'b0, 8, 1'b0);
        endTest("monitor abort");
        for (int n = 0; n < 3; n++) begin : rnd
            logic [7:0] d[$];
            int len;
            len = n ? 2 + $urandom % 4 : 23;
            d.delete();
            repeat (len) d.push_back(8'($urandom));
            // Keep the first byte clear of the parameter-request byte 00
            d[0][7] = 1'b1;
            request(d, 1'b1, 4'h0, 1'b0);
            waitDone(1'b1, 400, 1'b1);
            endTest("random request");
        end
        for (int i = 0; i < 3; i++) begin
            cmd(CMD_SET_TX_IDENTIFIER, 8'h55);
            cmd(CMD_SET_REPLY_TIMEOUT, 8'h07);
            cmd(rc[i], 8'h00);
            `CHK(txIdentifier, 8'hAC)
            `CHK(replyTimeout, 8'h0F)
        end
        endTest("restore");
        end_sim();
    end
endmodule : vehicle_bus_request_timing_test
